// [design/drive_status_cmd.v]
// drive status selector, alarm overlay and parameter command interpreter
//
// The plain strobed port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "drive_status_defs.vh"

////////////////////////////////////////////////////////////////////////////////
module drive_status_cmd #(
   parameter ALT_CYCLES = `ALT_CYCLES
)(
   input  wire        clk,
   input  wire        rstn,
   input  wire [3:0]  addr,
   input  wire [31:0] wdata,
   input  wire        wr,
   input  wire        rd,
   output reg  [31:0] rdata,
   input  wire        hw_enable,
   input  wire        run_cmd,
   input  wire        zero_speed,
   input  wire        supply_loss,
   input  wire        dc_inject,
   input  wire        trip,
   input  wire [7:0]  trip_code,
   input  wire        under_volt,
   input  wire        autotune_busy,
   input  wire        limit_stop,
   input  wire        slot_alarm,
   input  wire        low_ac,
   input  wire        current_limit,
   input  wire [15:0] load_pct,
   input  wire        editing,
   input  wire        key_reset,
   input  wire        basic_enter,
   input  wire        save_done,
   output reg         output_stage_on,
   output reg  [2:0]  status_code,
   output reg  [7:0]  shown_trip,
   output reg         show_alarm,
   output reg  [7:0]  alarms,
   output reg         save_req,
   output reg         load_def50,
   output reg         load_def60,
   output reg  [1:0]  op_mode
);

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers: three stages, a change counts when stages 2 and 3 agree
   localparam NSYNC = 15;
   wire [NSYNC-1:0] pin_in;
   reg  [NSYNC-1:0] s1_r;
   reg  [NSYNC-1:0] s2_r;
   reg  [NSYNC-1:0] s3_r;
   reg  [NSYNC-1:0] pin_r;
   assign pin_in = {basic_enter, key_reset, editing, current_limit, low_ac, slot_alarm,
                    limit_stop, autotune_busy, under_volt, trip, dc_inject, supply_loss,
                    zero_speed, run_cmd, hw_enable};
   genvar gi;
   generate
      for (gi = 0; gi < NSYNC; gi = gi + 1)
      begin : g_sync
         always @(posedge clk or negedge rstn)
         begin
            if (!rstn)
            begin
               s1_r[gi]  <= 1'b0;
               s2_r[gi]  <= 1'b0;
               s3_r[gi]  <= 1'b0;
               pin_r[gi] <= 1'b0;
            end
            else
            begin
               s1_r[gi] <= pin_in[gi];
               s2_r[gi] <= s1_r[gi];
               s3_r[gi] <= s2_r[gi];
               if (s2_r[gi] == s3_r[gi])
                  pin_r[gi] <= s3_r[gi];
            end
         end
      end
   endgenerate
   wire hw_en_s  = pin_r[0];
   wire run_s    = pin_r[1];
   wire zero_s   = pin_r[2];
   wire sloss_s  = pin_r[3];
   wire dcinj_s  = pin_r[4];
   wire trip_s   = pin_r[5];
   wire uv_s     = pin_r[6];
   wire tune_s   = pin_r[7];
   wire limit_s  = pin_r[8];
   wire slot_s   = pin_r[9];
   wire lowac_s  = pin_r[10];
   wire ilim_s   = pin_r[11];
   wire edit_s   = pin_r[12];
   wire key_s    = pin_r[13];
   wire enter_s  = pin_r[14];
   reg  key_d_r;
   reg  enter_d_r;

   ////////////////////////////////////////////////////////////////////////////
   // software registers
   reg  [31:0] ctrl_r;
   reg  [15:0] menu_cmd_r;
   reg  [15:0] brake_acc_r;
   reg  [15:0] motor_acc_r;
   reg  [15:0] drive_therm_r;
   reg  [2:0]  events_r;
   wire        sw_en = ctrl_r[`CTRL_SW_EN_BIT];
   wire        enabled = hw_en_s & sw_en;
   wire        wr_reset = wr && (addr == `REG_RESET_PAR) && (wdata[15:0] == `RESET_CODE);
   wire        wr_mode = wr && (addr == `REG_MODE) && !enabled &&
                         ((wdata[1:0] == `MODE_SCALAR) || (wdata[1:0] == `MODE_FLUX)) &&
                         (wdata[31:2] == 30'h0) && (wdata[1:0] != op_mode);
   wire        trigger = (key_s & ~key_d_r) | wr_reset;
   wire        enter_edge = enter_s & ~enter_d_r;
   reg         save_nxt;
   reg         d50_nxt;
   reg         d60_nxt;
   reg         clr_cmd;

   // armed command decode on reset trigger
   always @*
   begin
      save_nxt = 1'b0;
      d50_nxt  = 1'b0;
      d60_nxt  = 1'b0;
      clr_cmd  = 1'b0;
      if (trigger)
      begin
         if (uv_s)
         begin
            if (menu_cmd_r == `CMD_SAVE_UV)
               save_nxt = 1'b1;
         end
         else if (menu_cmd_r == `CMD_SAVE)
            save_nxt = 1'b1;
         if (!enabled && (menu_cmd_r == `CMD_DEF50))
            d50_nxt = 1'b1;
         if (!enabled && (menu_cmd_r == `CMD_DEF60))
            d60_nxt = 1'b1;
         clr_cmd = save_nxt | d50_nxt | d60_nxt;
      end
      if (wr_mode)
         save_nxt = 1'b1;
      if (enter_edge)
         save_nxt = 1'b1;
   end

   always @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         ctrl_r        <= `CTRL_RESET_VAL;
         menu_cmd_r    <= `CMD_NONE;
         brake_acc_r   <= 16'h0000;
         motor_acc_r   <= 16'h0000;
         drive_therm_r <= 16'h0000;
         op_mode       <= `MODE_SCALAR;
         save_req      <= 1'b0;
         load_def50    <= 1'b0;
         load_def60    <= 1'b0;
         events_r      <= 3'h0;
         key_d_r       <= 1'b0;
         enter_d_r     <= 1'b0;
      end
      else
      begin
         key_d_r   <= key_s;
         enter_d_r <= enter_s;
         // advanced-menu writes only store, except a legal mode change, which also requests a save
         if (wr && addr == `REG_CTRL)
            ctrl_r <= wdata;
         if (clr_cmd)
            menu_cmd_r <= `CMD_NONE;
         else if (wr && addr == `REG_MENU_CMD)
            menu_cmd_r <= wdata[15:0];
         if (wr && addr == `REG_BRAKE_ACC)
            brake_acc_r <= wdata[15:0];
         if (wr && addr == `REG_MOTOR_ACC)
            motor_acc_r <= wdata[15:0];
         if (wr && addr == `REG_DRIVE_THERM)
            drive_therm_r <= wdata[15:0];
         if (wr_mode)
            op_mode <= wdata[1:0];
         // save and defaults pulses only; security status and code live elsewhere
         save_req   <= save_nxt | d50_nxt | d60_nxt;
         load_def50 <= d50_nxt;
         load_def60 <= d60_nxt;
         // sticky done events: set wins over clear
         events_r <= ((wr && addr == `REG_EVENT) ? (events_r & ~wdata[2:0]) : events_r)
                     | {save_done, d60_nxt, d50_nxt};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // status selection and alarms
   reg [2:0] status_nxt;
   reg       stage_nxt;
   reg [7:0] alarm_nxt;
   always @*
   begin
      stage_nxt = 1'b1;
      if (trip_s)
      begin
         status_nxt = `ST_FAULT_HALT;
         stage_nxt  = 1'b0;
      end
      else if (uv_s)
      begin
         status_nxt = `ST_UNDER_VOLT;
         stage_nxt  = 1'b0;
      end
      else if (!enabled)
      begin
         status_nxt = `ST_BLOCKED;
         stage_nxt  = 1'b0;
      end
      else if (!run_s)
      begin
         status_nxt = `ST_ARMED_IDLE;
         stage_nxt  = 1'b0;
      end
      else if (sloss_s)
         status_nxt = `ST_MAINS_DROP;
      else if (dcinj_s)
         status_nxt = `ST_DC_BRAKE;
      else if (zero_s)
         status_nxt = `ST_STOP;
      else
         status_nxt = `ST_RUN;
      alarm_nxt = 8'h00;
      alarm_nxt[`AL_BRAKE]     = (brake_acc_r >= `THR_BRAKE_PM);
      alarm_nxt[`AL_MOTOR]     = (motor_acc_r >= `THR_MOTOR_PM) &&
                                 (load_pct > `THR_LOAD_PCT);
      alarm_nxt[`AL_DRIVE]     = (drive_therm_r > `THR_DRIVE_PCT);
      alarm_nxt[`AL_TUNE]      = tune_s;
      alarm_nxt[`AL_TRAVEL]    = limit_s;
      alarm_nxt[`AL_SLOT]      = slot_s;
      alarm_nxt[`AL_MAINS_LOW] = lowac_s;
      alarm_nxt[`AL_CLAMP]     = ilim_s;
   end

   // alternation timer for alarm overlay
   reg [31:0] alt_cnt_r;
   reg        phase_r;
   always @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         alt_cnt_r       <= 32'h0;
         phase_r         <= 1'b0;
         status_code     <= `ST_BLOCKED;
         output_stage_on <= 1'b0;
         shown_trip      <= 8'h00;
         alarms          <= 8'h00;
         show_alarm      <= 1'b0;
      end
      else
      begin
         if (alt_cnt_r >= ALT_CYCLES - 1)
         begin
            alt_cnt_r <= 32'h0;
            phase_r   <= ~phase_r;
         end
         else
            alt_cnt_r <= alt_cnt_r + 32'h1;
         status_code     <= status_nxt;
         output_stage_on <= stage_nxt;
         shown_trip      <= trip_s ? trip_code : 8'h00;
         alarms          <= alarm_nxt;
         show_alarm      <= (alarm_nxt != 8'h00) && phase_r && !edit_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // register read port
   always @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         rdata <= 32'h0;
      else if (rd)
      begin
         if (addr == `REG_CTRL)
            rdata <= ctrl_r;
         else if (addr == `REG_MENU_CMD)
            rdata <= {16'h0, menu_cmd_r};
         else if (addr == `REG_MODE)
            rdata <= {30'h0, op_mode};
         else if (addr == `REG_BRAKE_ACC)
            rdata <= {16'h0, brake_acc_r};
         else if (addr == `REG_MOTOR_ACC)
            rdata <= {16'h0, motor_acc_r};
         else if (addr == `REG_DRIVE_THERM)
            rdata <= {16'h0, drive_therm_r};
         else if (addr == `REG_STATUS)
            rdata <= {19'h0, enabled, output_stage_on, shown_trip, status_code};
         else if (addr == `REG_ALARM)
            rdata <= {24'h0, alarms};
         else if (addr == `REG_EVENT)
            rdata <= {29'h0, events_r};
         else
            rdata <= 32'h0;
      end
      else
         rdata <= 32'h0;
   end

endmodule
`default_nettype wire

// [include/drive_status_defs.vh]
// constants for the drive status and parameter command block
`ifndef DRIVE_STATUS_DEFS_VH
`define DRIVE_STATUS_DEFS_VH

// register indices (word address = index)
`define REG_CTRL          4'h0
`define REG_MENU_CMD      4'h1
`define REG_RESET_PAR     4'h2
`define REG_MODE          4'h3
`define REG_BRAKE_ACC     4'h4
`define REG_MOTOR_ACC     4'h5
`define REG_DRIVE_THERM   4'h6
`define REG_STATUS        4'h7
`define REG_ALARM         4'h8
`define REG_EVENT         4'h9

// control register fields
`define CTRL_SW_EN_BIT    0
`define CTRL_RESET_VAL    32'h0000_0001

// command codes
`define CMD_NONE          16'h0000
`define CMD_SAVE          16'h03E8
`define CMD_SAVE_UV       16'h03E9
`define CMD_DEF50         16'h04D1
`define CMD_DEF60         16'h04DC
`define RESET_CODE        16'h0064

// operating modes
`define MODE_SCALAR       2'h1
`define MODE_FLUX         2'h2

// thresholds, per mille of trip value / percent
`define THR_BRAKE_PM      16'h02EE
`define THR_MOTOR_PM      16'h02EE
`define THR_LOAD_PCT      16'h0064
`define THR_DRIVE_PCT     16'h005A

// status indication codes
`define ST_BLOCKED        3'h0
`define ST_ARMED_IDLE     3'h1
`define ST_STOP           3'h2
`define ST_MAINS_DROP     3'h3
`define ST_DC_BRAKE       3'h4
`define ST_FAULT_HALT     3'h5
`define ST_UNDER_VOLT     3'h6
`define ST_RUN            3'h7

// alarm bit positions
`define AL_BRAKE          0
`define AL_MOTOR          1
`define AL_DRIVE          2
`define AL_TUNE           3
`define AL_TRAVEL         4
`define AL_SLOT           5
`define AL_MAINS_LOW      6
`define AL_CLAMP          7

// alternation period in clocks (0.5 s at 10 MHz)
`define ALT_TIME_MS       500
`define CLK_KHZ           10000
`define ALT_CYCLES        (`ALT_TIME_MS * `CLK_KHZ)

`endif

// [test/drive_status_cmd_assertions.sv]
// checker for the drive status selector and command interpreter
`timescale 1ns/100ps
`default_nettype none
`include "drive_status_defs.vh"
module drive_status_cmd_chk (
   input wire logic        clk,
   input wire logic        rstn,
   input wire logic        editing,
   input wire logic [15:0] load_pct,
   input wire logic [2:0]  status_code,
   input wire logic        output_stage_on,
   input wire logic [7:0]  shown_trip,
   input wire logic        show_alarm,
   input wire logic [7:0]  alarms,
   input wire logic        save_req,
   input wire logic        load_def50,
   input wire logic        load_def60,
   input wire logic [1:0]  op_mode
);
   // counts cycles of steady editing, past the input filter delay
   int edit_cnt;
   always @(posedge clk or negedge rstn)
      if (!rstn)
         edit_cnt <= 0;
      else
         edit_cnt <= !editing ? 0 : (edit_cnt < 9) ? edit_cnt + 1 : edit_cnt;
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   blocked_stage_a: assert property (status_code == `ST_BLOCKED |-> !output_stage_on)
      else $error("stage on while blocked");
   fault_stage_a: assert property (status_code == `ST_FAULT_HALT |-> !output_stage_on)
      else $error("stage on while tripped");
   running_stage_a: assert property (
      status_code inside {`ST_STOP, `ST_MAINS_DROP, `ST_DC_BRAKE} |-> output_stage_on)
      else $error("stage off while running");
   trip_hidden_a: assert property (status_code != `ST_FAULT_HALT |-> shown_trip == 8'h00)
      else $error("trip code shown without trip");
   alarm_phase_a: assert property ((alarms == 8'h00) [*3] |-> !show_alarm)
      else $error("alarm phase without alarm");
   edit_quiet_a: assert property (edit_cnt >= 8 |-> !show_alarm)
      else $error("alarm shown while editing");
   motor_load_a: assert property (alarms[`AL_MOTOR] |-> load_pct > `THR_LOAD_PCT
      || $past(load_pct) > `THR_LOAD_PCT) else $error("motor alarm at low load");
   mode_legal_a: assert property (op_mode == `MODE_SCALAR || op_mode == `MODE_FLUX)
      else $error("illegal mode");
   mode_save_a: assert property (
      !$stable(op_mode) |-> !output_stage_on ##[0:2] save_req)
      else $error("mode change without save");
   def_pulse_a: assert property (
      load_def50 || load_def60 |=> !(load_def50 || load_def60))
      else $error("defaults pulse too long");
   cover property (save_req);
   cover property (show_alarm);
   cover property (load_def60);
endmodule
bind drive_status_cmd drive_status_cmd_chk chk_inst (.clk(clk), .rstn(rstn), .editing(editing),
   .load_pct(load_pct), .status_code(status_code), .output_stage_on(output_stage_on),
   .shown_trip(shown_trip), .show_alarm(show_alarm), .alarms(alarms), .save_req(save_req),
   .load_def50(load_def50), .load_def60(load_def60), .op_mode(op_mode));
`default_nettype wire

// [test/keypad_store_model.sv]
// keypad buttons and parameter store answering save and default pulses
`timescale 1ns/100ps
`default_nettype none
module keypad_store_model #(
   parameter SAVE_DELAY = 3
)(
   input  wire logic clk,
   input  wire logic save_req,
   input  wire logic load_def50,
   input  wire logic load_def60,
   output var  logic key_reset,
   output var  logic basic_enter,
   output var  logic save_done
);
   int n_save = 0;
   int n_def50 = 0;
   int n_def60 = 0;
   int wait_cnt = 0;
   initial
   begin
      key_reset = 1'b0;
      basic_enter = 1'b0;
      save_done = 1'b0;
   end
   // store finishes each save a few cycles later
   always @(posedge clk)
   begin
      n_save += save_req;
      n_def50 += load_def50;
      n_def60 += load_def60;
      save_done <= (wait_cnt == 1);
      wait_cnt <= save_req ? SAVE_DELAY : (wait_cnt > 0) ? wait_cnt - 1 : 0;
   end
   // button held long enough to pass the input filter
   task automatic press(input logic enter);
      @(posedge clk);
      if (enter)
         basic_enter <= 1'b1;
      else
         key_reset <= 1'b1;
      repeat (8) @(posedge clk);
      basic_enter <= 1'b0;
      key_reset <= 1'b0;
      repeat (8) @(posedge clk);
   endtask
endmodule
`default_nettype wire

// [test/drive_status_and_param_command_bench.sv]
// self-checking bench for the drive status and command block
`timescale 1ns/100ps
`default_nettype none
`include "drive_status_defs.vh"
module drive_status_and_param_command_bench;
   logic        clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, editing = 1'b0;
   logic [3:0]  addr = 4'h0;
   logic [31:0] wdata = 32'h0, v;
   logic [6:0]  cond = 7'h00;
   logic [4:0]  amir = 5'h00;
   logic [7:0]  trip_code = 8'h00;
   logic [15:0] load_pct = 16'h0000, b, m, t;
   wire logic  [31:0] rdata;
   wire logic  [7:0]  shown_trip, alarms;
   wire logic  [2:0]  status_code;
   wire logic  [1:0]  op_mode;
   wire logic         stage, show_alarm, save_req, def50, def60, key_reset, basic_enter, save_done;
   int num_errors = 0, n_tests = 0, es = 0, cnt;
   logic sw;
   drive_status_cmd #(.ALT_CYCLES(8)) drive_status_cmd_inst (.clk(clk), .rstn(rstn), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .hw_enable(cond[6]), .run_cmd(cond[5]),
      .zero_speed(cond[4]), .supply_loss(cond[3]), .dc_inject(cond[2]), .trip(cond[1]),
      .trip_code(trip_code), .under_volt(cond[0]), .autotune_busy(amir[4]),
      .limit_stop(amir[3]), .slot_alarm(amir[2]), .low_ac(amir[1]), .current_limit(amir[0]),
      .load_pct(load_pct), .editing(editing), .key_reset(key_reset), .basic_enter(basic_enter),
      .save_done(save_done), .output_stage_on(stage), .status_code(status_code),
      .shown_trip(shown_trip), .show_alarm(show_alarm), .alarms(alarms), .save_req(save_req),
      .load_def50(def50), .load_def60(def60), .op_mode(op_mode));
   keypad_store_model kp (.clk(clk), .save_req(save_req), .load_def50(def50),
      .load_def60(def60), .key_reset(key_reset), .basic_enter(basic_enter),
      .save_done(save_done));
   initial
   begin
      forever #50 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [3:0] a);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 v = rdata;
   endtask
   task automatic settle;
      repeat (10) @(posedge clk);
      #1;
   endtask
   // command code, then reset from serial or from the keypad
   task automatic trig(input logic [15:0] code, input logic serial);
      wr_reg(`REG_MENU_CMD, {16'h0000, code});
      if (serial)
         wr_reg(`REG_RESET_PAR, {16'h0000, `RESET_CODE});
      else
         kp.press(1'b0);
      settle;
   endtask
   function automatic logic [3:0] exp_st(input logic [6:0] c, input logic s);
      if (c[1]) return {1'b0, `ST_FAULT_HALT};
      if (c[0]) return {1'b0, `ST_UNDER_VOLT};
      if (!(c[6] && s)) return {1'b0, `ST_BLOCKED};
      if (!c[5]) return {1'b0, `ST_ARMED_IDLE};
      if (c[3]) return {1'b1, `ST_MAINS_DROP};
      if (c[2]) return {1'b1, `ST_DC_BRAKE};
      if (c[4]) return {1'b1, `ST_STOP};
      return {1'b1, `ST_RUN};
   endfunction
   function automatic logic [7:0] exp_al(input logic [4:0] a);
      return {a[0], a[1], a[2], a[3], a[4], t > `THR_DRIVE_PCT,
              m >= `THR_MOTOR_PM && load_pct > `THR_LOAD_PCT, b >= `THR_BRAKE_PM};
   endfunction
   task end_sim;
      $display("comparisons %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial
   begin
      #(100 * 40000);
      num_errors++;
      end_sim;
   end
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      void'($urandom(32'h23BA));
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      settle;
      check("mode", op_mode, `MODE_SCALAR);
      check("status", status_code, `ST_BLOCKED);
      for (int i = 0; i < 30; i++)
      begin
         b = 16'h02ED + 16'($urandom_range(2, 0));
         m = 16'h02ED + 16'($urandom_range(2, 0));
         t = 16'h0059 + 16'($urandom_range(2, 0));
         sw = (i < 5) ? 1'b1 : 1'($urandom);
         cond <= (i < 5) ? (7'h60 | (7'h10 >> i)) : 7'($urandom);
         amir <= 5'($urandom);
         trip_code <= 8'($urandom);
         load_pct <= 16'h0063 + 16'($urandom_range(2, 0));
         wr_reg(`REG_CTRL, {31'h0, sw});
         wr_reg(`REG_BRAKE_ACC, {16'h0000, b});
         wr_reg(`REG_MOTOR_ACC, {16'h0000, m});
         wr_reg(`REG_DRIVE_THERM, {16'h0000, t});
         settle;
         check("status", {stage, status_code}, exp_st(cond, sw));
         check("trip", shown_trip, cond[1] ? trip_code : 8'h00);
         check("alarms", alarms, exp_al(amir));
         rd_reg(`REG_ALARM);
         check("alarm reg", v[7:0], exp_al(amir));
      end
      for (int e = 0; e < 2; e++)
      begin
         cond <= 7'h40;
         amir <= 5'h01;
         editing <= e[0];
         settle;
         cnt = 0;
         repeat (40) @(posedge clk) cnt += show_alarm;
         check("alternation", cnt > 0 && cnt < 40, !e[0]);
      end
      editing <= 1'b0;
      wr_reg(`REG_CTRL, 32'h1);
      trig(`CMD_SAVE, 1'b1);
      es++;
      check("saves", kp.n_save, es);
      rd_reg(`REG_MENU_CMD);
      check("menu cmd", v, 32'h0);
      rd_reg(`REG_STATUS);
      check("status reg", v, {19'h0, 1'b1, 1'b0, 8'h00, `ST_ARMED_IDLE});
      trig(`CMD_SAVE, 1'b0);
      es++;
      check("saves", kp.n_save, es);
      trig(`CMD_DEF50, 1'b1);
      check("def50 enabled", kp.n_def50, 0);
      wr_reg(`REG_CTRL, 32'h0);
      wr_reg(`REG_RESET_PAR, {16'h0000, `RESET_CODE});
      settle;
      check("def50", kp.n_def50, 1);
      trig(`CMD_DEF60, 1'b0);
      check("def60", kp.n_def60, 1);
      rd_reg(`REG_EVENT);
      check("events", v, 32'h0000_0007);
      wr_reg(`REG_EVENT, 32'h0000_0007);
      rd_reg(`REG_EVENT);
      check("events clear", v, 32'h0);
      es = kp.n_save;
      // let the under-voltage level pass the input filter before the command
      cond <= 7'h41;
      settle;
      trig(`CMD_SAVE, 1'b1);
      check("uv 1000", kp.n_save, es);
      trig(`CMD_SAVE_UV, 1'b1);
      es++;
      check("uv 1001", kp.n_save, es);
      cond <= 7'h40;
      wr_reg(`REG_MODE, 32'h3);
      wr_reg(`REG_MODE, {30'h0, `MODE_FLUX});
      settle;
      check("mode", op_mode, `MODE_FLUX);
      es++;
      check("mode save", kp.n_save, es);
      rd_reg(`REG_MODE);
      check("mode reg", v, {30'h0, `MODE_FLUX});
      wr_reg(`REG_CTRL, 32'h1);
      wr_reg(`REG_MODE, {30'h0, `MODE_SCALAR});
      settle;
      check("mode enabled", op_mode, `MODE_FLUX);
      kp.press(1'b1);
      es++;
      check("enter save", kp.n_save, es);
      rd_reg(4'hF);
      check("unmapped", v, 32'h0);
      end_sim;
   end
endmodule
`default_nettype wire
